// File: design/atx_tx_slot_cfg.sv
/*
 * Transmit configuration and slot placement for audio port channels 2 to 4.
 * Register side runs on REF_CLK through a simple decoded register port fed by
 * the control interface decoder; the serial side runs on the bit clock.
 * Assumes channel samples arrive MSB aligned in the bit clock domain and that
 * word length, format and pin selects are quasi-static on REF_CLK.
 */
// Function
// RULE_01 - Channel 2 register bits 7:6 are reserved, read zero, writes ignored.
// RULE_02 - Channel 2 source bit 5, reset 1: 0 tri-states, 1 sends converter data.
// RULE_03 - Channel 2 slot field bits 4:0, reset 1, picks its frame slot.
// RULE_04 - Codes 0-15 TDM slot or left slot; 16-31 TDM slot or right slot N-16.
// RULE_05 - A tri-state source releases the data output during the channel slot.
// RULE_06 - Channel 3 and 4 registers bit 7 reserved, reads zero, writes ignored.
// RULE_07 - Channel 3 source bits 6:5, reset 0: off, mic 3, or battery data.
// RULE_08 - Channel 3 register at 0x20, reset 0x02, slot defaults to 2.
// RULE_09 - Channel 4 source bits 6:5, reset 0: off, mic 4, or temperature data.
// RULE_10 - Channel 4 register at 0x21, reset 0x03, slot defaults to 3.
// RULE_11 - Software must not program source code 3 for channel 3 or 4.
// RULE_12 - Per-channel pin select: 0 routes to output A, 1 to output B.
// RULE_13 - Each word goes out MSB first in its slot at the global word length.
module atx_tx_slot_cfg
	import atx_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic [2:0]  CH_PIN_SEL,
	input  wire logic [1:0]  FORMAT,
	input  wire logic [1:0]  WORD_LEN,
	input  wire logic        BIT_CLK,
	input  wire logic        FRAME_SYNC,
	input  wire logic [31:0] CH2_CONV_DATA,
	input  wire logic [31:0] CH3_MIC_DATA,
	input  wire logic [31:0] CH3_VBAT_DATA,
	input  wire logic [31:0] CH4_MIC_DATA,
	input  wire logic [31:0] CH4_TEMP_DATA,
	output logic             SDOUT_A_O,
	output logic             SDOUT_A_OE,
	output logic             SDOUT_B_O,
	output logic             SDOUT_B_OE
);

	// ----------------------------------------------------------------
	// Register domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       src2;
		logic [4:0] slot2;
		logic [1:0] src3;
		logic [4:0] slot3;
		logic [1:0] src4;
		logic [4:0] slot4;
		logic [2:0] pin;
		logic [1:0] fmt;
		logic [1:0] wl;
	} atx_cfg_type;

	typedef struct packed {
		atx_cfg_type cfg;
		atx_cfg_type shadow;
		logic [7:0]  rdata;
		logic        dirty;
		logic        req;
		logic        ack_s1;
		logic        ack_s2;
		logic        first;
	} atx_ref_type;

	atx_ref_type r_q;
	atx_ref_type r_d;

	// Link state variables declared here so the register process can read the ack
	typedef struct packed {
		logic        fs_s1;
		logic        fs_s2;
		logic        fs_s3;
		logic        req_s1;
		logic        req_s2;
		logic        req_s3;
		atx_cfg_type cfg;
		logic        active;
		logic        right;
		logic        pre;
		logic [4:0]  bit_cnt;
		logic [5:0]  slot;
		logic        a_o;
		logic        a_oe;
		logic        b_o;
		logic        b_oe;
	} atx_link_type;

	atx_link_type l_q;
	atx_link_type l_d;

	always_comb begin
		r_d = r_q;
		r_d.first = 1'b0;
		r_d.ack_s1 = l_q.req_s3;
		r_d.ack_s2 = r_q.ack_s1;
		r_d.cfg.pin = CH_PIN_SEL;
		r_d.cfg.fmt = FORMAT;
		r_d.cfg.wl = WORD_LEN;
		// Reserved bits are simply not stored
		if (REG_WR) begin
			unique case (REG_ADDR)
				ATX_OFS_CH2: begin
					r_d.cfg.src2 = REG_WDATA[ATX_SRC2_MSB]; // [RULE_01] [RULE_02]
					r_d.cfg.slot2 = REG_WDATA[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_03]
				end
				ATX_OFS_CH3: begin
					r_d.cfg.src3 = REG_WDATA[ATX_SRC34_MSB:ATX_SRC_LSB]; // [RULE_06] [RULE_07]
					r_d.cfg.slot3 = REG_WDATA[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_08]
				end
				ATX_OFS_CH4: begin
					r_d.cfg.src4 = REG_WDATA[ATX_SRC34_MSB:ATX_SRC_LSB]; // [RULE_06] [RULE_09]
					r_d.cfg.slot4 = REG_WDATA[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_10]
				end
				default: begin
				end
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				ATX_OFS_CH2: r_d.rdata = {2'h0, r_q.cfg.src2, r_q.cfg.slot2}; // [RULE_01]
				ATX_OFS_CH3: r_d.rdata = {1'h0, r_q.cfg.src3, r_q.cfg.slot3}; // [RULE_06]
				ATX_OFS_CH4: r_d.rdata = {1'h0, r_q.cfg.src4, r_q.cfg.slot4}; // [RULE_06]
				default:     r_d.rdata = 8'h00;
			endcase
		end
		// Hand the whole word over only when the previous handover is acknowledged,
		// so the shadow never moves while the link side may be copying it
		if (r_q.cfg != r_d.cfg) begin
			r_d.dirty = 1'b1;
		end
		if ((r_q.req == r_q.ack_s2) && r_q.dirty) begin
			r_d.shadow = r_q.cfg;
			r_d.req = ~r_q.req;
			r_d.dirty = (r_q.cfg != r_d.cfg);
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			r_q <= '0;
			r_q.cfg.src2 <= ATX_RST_CH2[ATX_SRC2_MSB]; // [RULE_02]
			r_q.cfg.slot2 <= ATX_RST_CH2[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_03]
			r_q.cfg.src3 <= ATX_RST_CH3[ATX_SRC34_MSB:ATX_SRC_LSB]; // [RULE_07]
			r_q.cfg.slot3 <= ATX_RST_CH3[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_08]
			r_q.cfg.src4 <= ATX_RST_CH4[ATX_SRC34_MSB:ATX_SRC_LSB]; // [RULE_09]
			r_q.cfg.slot4 <= ATX_RST_CH4[ATX_SLOT_MSB:ATX_SLOT_LSB]; // [RULE_10]
			r_q.dirty <= 1'b1;
			r_q.first <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign REG_RDATA = r_q.rdata;

	// ----------------------------------------------------------------
	// Link domain: frame counter and slot placement
	// ----------------------------------------------------------------
	logic       tdm_mode;
	logic       slot_ok;
	logic [4:0] wlast;
	logic [2:0] src_on;
	logic [4:0] codes [3];
	logic [31:0] samples [3];
	logic [2:0] drv_a;
	logic [2:0] drv_b;
	logic [2:0] bits;

	always_comb begin
		tdm_mode = (atx_fmt_type'(l_q.cfg.fmt) == ATX_FMT_TDM);
		slot_ok = l_q.active && !l_q.pre;
		unique case (l_q.cfg.wl)
			ATX_WL_16: wlast = ATX_WLAST_16;
			ATX_WL_20: wlast = ATX_WLAST_20;
			ATX_WL_24: wlast = ATX_WLAST_24;
			ATX_WL_32: wlast = ATX_WLAST_32;
		endcase
		// Reserved source code 3 is treated as off
		src_on[0] = l_q.cfg.src2; // [RULE_02] [RULE_05]
		src_on[1] = (l_q.cfg.src3 == ATX_SRC_MIC) || (l_q.cfg.src3 == ATX_SRC_MEAS); // [RULE_07] [RULE_11]
		src_on[2] = (l_q.cfg.src4 == ATX_SRC_MIC) || (l_q.cfg.src4 == ATX_SRC_MEAS); // [RULE_09] [RULE_11]
		samples[0] = CH2_CONV_DATA;
		samples[1] = (l_q.cfg.src3 == ATX_SRC_MEAS) ? CH3_VBAT_DATA : CH3_MIC_DATA; // [RULE_07]
		samples[2] = (l_q.cfg.src4 == ATX_SRC_MEAS) ? CH4_TEMP_DATA : CH4_MIC_DATA; // [RULE_09]
		codes[0] = l_q.cfg.slot2;
		codes[1] = l_q.cfg.slot3;
		codes[2] = l_q.cfg.slot4;
	end

	for (genvar ch = 0; ch < 3; ch++) begin : g_lane
		atx_slot_lane u_lane (
			.tdm_mode   (tdm_mode),
			.slot_ok    (slot_ok),
			.right_half (l_q.right),
			.slot_idx   (l_q.slot),
			.bit_idx    (l_q.bit_cnt),
			.slot_code  (codes[ch]),
			.src_on     (src_on[ch]),
			.pin_sel    (l_q.cfg.pin[ch]),
			.sample     (samples[ch]),
			.drive_a    (drv_a[ch]),
			.drive_b    (drv_b[ch]),
			.bit_out    (bits[ch])
		);
	end

	always_comb begin
		l_d = l_q;
		l_d.fs_s1 = FRAME_SYNC;
		l_d.fs_s2 = l_q.fs_s1;
		l_d.fs_s3 = l_q.fs_s2;
		l_d.req_s1 = r_q.req;
		l_d.req_s2 = l_q.req_s1;
		l_d.req_s3 = l_q.req_s2;
		if (l_q.req_s2 != l_q.req_s3) begin
			l_d.cfg = r_q.shadow;
		end
		// Bit and slot counting within the current half or frame
		if (l_q.pre) begin
			l_d.pre = 1'b0;
		end else if (l_q.bit_cnt == wlast) begin
			l_d.bit_cnt = 5'h00;
			l_d.slot = (l_q.slot == ATX_SLOT_SAT) ? l_q.slot : l_q.slot + 6'h01;
		end else begin
			l_d.bit_cnt = l_q.bit_cnt + 5'h01;
		end
		// Frame or half starts on a sync edge; I2S adds one bit of delay
		if (l_q.fs_s2 != l_q.fs_s3) begin
			unique case (atx_fmt_type'(l_q.cfg.fmt))
				ATX_FMT_TDM: begin
					l_d.active = l_q.fs_s2 ? 1'b1 : l_q.active;
					l_d.right = 1'b0;
					if (l_q.fs_s2) begin
						l_d.bit_cnt = 5'h00;
						l_d.slot = 6'h00;
						l_d.pre = 1'b0;
					end
				end
				ATX_FMT_I2S: begin
					l_d.active = 1'b1;
					l_d.right = l_q.fs_s2;
					l_d.bit_cnt = 5'h00;
					l_d.slot = 6'h00;
					l_d.pre = 1'b1;
				end
				ATX_FMT_LJ: begin
					l_d.active = 1'b1;
					l_d.right = !l_q.fs_s2;
					l_d.bit_cnt = 5'h00;
					l_d.slot = 6'h00;
					l_d.pre = 1'b0;
				end
				default: begin
					l_d.active = 1'b0;
				end
			endcase
		end
		// Lowest channel wins when two share a slot on one pin
		l_d.a_oe = |drv_a; // [RULE_05] [RULE_12]
		l_d.b_oe = |drv_b; // [RULE_12]
		l_d.a_o = drv_a[0] ? bits[0] : (drv_a[1] ? bits[1] : (drv_a[2] & bits[2])); // [RULE_13]
		l_d.b_o = drv_b[0] ? bits[0] : (drv_b[1] ? bits[1] : (drv_b[2] & bits[2])); // [RULE_13]
	end

	always_ff @(posedge BIT_CLK or posedge RST) begin
		if (RST) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	assign SDOUT_A_O = l_q.a_o;
	assign SDOUT_A_OE = l_q.a_oe;
	assign SDOUT_B_O = l_q.b_o;
	assign SDOUT_B_OE = l_q.b_oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_ch2_rsv;
		@(posedge REF_CLK) disable iff (RST)
		REG_RD && (REG_ADDR == ATX_OFS_CH2) |=> (REG_RDATA[7:6] == 2'h0);
	endproperty
	a_ch2_rsv: assert property (p_ch2_rsv) else $error("ch2 reserved bits not zero"); // [RULE_01]

	property p_ch2_src;
		@(posedge REF_CLK) disable iff (RST)
		REG_WR && (REG_ADDR == ATX_OFS_CH2) ##1 !REG_WR ##1 REG_RD && (REG_ADDR == ATX_OFS_CH2) && !REG_WR
			|=> (REG_RDATA[5] == $past(REG_WDATA[5], 3));
	endproperty
	a_ch2_src: assert property (p_ch2_src) else $error("ch2 source readback wrong"); // [RULE_02]

	property p_ch2_slot;
		@(posedge REF_CLK) disable iff (RST)
		REG_WR && (REG_ADDR == ATX_OFS_CH2) |=> (r_q.cfg.slot2 == $past(REG_WDATA[4:0]));
	endproperty
	a_ch2_slot: assert property (p_ch2_slot) else $error("ch2 slot not stored"); // [RULE_03]

	property p_tdm_slot;
		@(posedge BIT_CLK) disable iff (RST)
		tdm_mode && drv_a[0] |-> (l_q.slot[4:0] == l_q.cfg.slot2) && (l_q.slot < ATX_TDM_SLOTS);
	endproperty
	a_tdm_slot: assert property (p_tdm_slot) else $error("ch2 drives outside its slot"); // [RULE_04]

	property p_release;
		@(posedge BIT_CLK) disable iff (RST)
		(src_on == 3'h0) |=> !SDOUT_A_OE && !SDOUT_B_OE;
	endproperty
	a_release: assert property (p_release) else $error("pin driven with all sources off"); // [RULE_05]

	property p_ch34_rsv;
		@(posedge REF_CLK) disable iff (RST)
		REG_RD && ((REG_ADDR == ATX_OFS_CH3) || (REG_ADDR == ATX_OFS_CH4)) |=> !REG_RDATA[7];
	endproperty
	a_ch34_rsv: assert property (p_ch34_rsv) else $error("ch3/ch4 reserved bit not zero"); // [RULE_06]

	property p_ch3_src;
		@(posedge REF_CLK) disable iff (RST)
		REG_WR && (REG_ADDR == ATX_OFS_CH3) |=> (r_q.cfg.src3 == $past(REG_WDATA[6:5]));
	endproperty
	a_ch3_src: assert property (p_ch3_src) else $error("ch3 source not stored"); // [RULE_07]

	property p_ch3_rst;
		@(posedge REF_CLK) disable iff (RST)
		r_q.first |-> ({1'b0, r_q.cfg.src3, r_q.cfg.slot3} == ATX_RST_CH3);
	endproperty
	a_ch3_rst: assert property (p_ch3_rst) else $error("ch3 reset value wrong"); // [RULE_08]

	property p_ch4_src;
		@(posedge REF_CLK) disable iff (RST)
		REG_WR && (REG_ADDR == ATX_OFS_CH4) |=> (r_q.cfg.src4 == $past(REG_WDATA[6:5]));
	endproperty
	a_ch4_src: assert property (p_ch4_src) else $error("ch4 source not stored"); // [RULE_09]

	property p_ch4_rst;
		@(posedge REF_CLK) disable iff (RST)
		r_q.first |-> ({1'b0, r_q.cfg.src4, r_q.cfg.slot4} == ATX_RST_CH4);
	endproperty
	a_ch4_rst: assert property (p_ch4_rst) else $error("ch4 reset value wrong"); // [RULE_10]

	property p_pin_b;
		@(posedge BIT_CLK) disable iff (RST)
		SDOUT_B_OE |-> $past(|(drv_b & l_q.cfg.pin));
	endproperty
	a_pin_b: assert property (p_pin_b) else $error("pin B driven by channel routed to A"); // [RULE_12]

	property p_msb_first;
		@(posedge BIT_CLK) disable iff (RST)
		drv_a[0] && (l_q.bit_cnt == 5'h00) |=> (SDOUT_A_O == $past(CH2_CONV_DATA[31]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("ch2 first bit is not the MSB"); // [RULE_13]

endmodule // atx_tx_slot_cfg

// File: inc/atx_pkg.sv
/*
 * Shared constants for the transmit slot configuration of channels 2 to 4:
 * register offsets, field positions, reset values, source codes, frame formats.
 * Assumes register offsets and data are eight bits wide.
 */
package atx_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ATX_OFS_CH2     = 8'h1F;
	localparam logic [7:0] ATX_OFS_CH3     = 8'h20;
	localparam logic [7:0] ATX_OFS_CH4     = 8'h21;
	localparam logic [7:0] ATX_RST_CH2     = 8'h21;
	localparam logic [7:0] ATX_RST_CH3     = 8'h02;
	localparam logic [7:0] ATX_RST_CH4     = 8'h03;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int         ATX_SLOT_LSB    = 0;
	localparam int         ATX_SLOT_MSB    = 4;
	localparam int         ATX_SRC_LSB     = 5;
	localparam int         ATX_SRC2_MSB    = 5;
	localparam int         ATX_SRC34_MSB   = 6;

	// ----------------------------------------------------------------
	// Source codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ATX_SRC_OFF     = 2'h0;
	localparam logic [1:0] ATX_SRC_MIC     = 2'h1;
	localparam logic [1:0] ATX_SRC_MEAS    = 2'h2;
	localparam logic [1:0] ATX_SRC_RSVD    = 2'h3;

	// ----------------------------------------------------------------
	// Frame formats and word lengths
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ATX_FMT_TDM = 2'b00,
		ATX_FMT_I2S = 2'b01,
		ATX_FMT_LJ  = 2'b10,
		ATX_FMT_RSV = 2'b11
	} atx_fmt_type;

	localparam logic [1:0] ATX_WL_16       = 2'h0;
	localparam logic [1:0] ATX_WL_20       = 2'h1;
	localparam logic [1:0] ATX_WL_24       = 2'h2;
	localparam logic [1:0] ATX_WL_32       = 2'h3;
	localparam logic [4:0] ATX_WLAST_16    = 5'h0F;
	localparam logic [4:0] ATX_WLAST_20    = 5'h13;
	localparam logic [4:0] ATX_WLAST_24    = 5'h17;
	localparam logic [4:0] ATX_WLAST_32    = 5'h1F;
	localparam logic [5:0] ATX_SLOT_SAT    = 6'h3F;
	localparam logic [5:0] ATX_HALF_SLOTS  = 6'h10;
	localparam logic [5:0] ATX_TDM_SLOTS   = 6'h20;
	localparam logic [4:0] ATX_SAMPLE_MSB  = 5'h1F;

endpackage

// File: design/atx_slot_lane.sv
/*
 * One transmit channel lane: decides whether the current slot belongs to the
 * channel and which output pin it drives, and picks the bit, MSB first.
 * Assumes slot and bit counters come from the link-clock frame counter.
 */
module atx_slot_lane
	import atx_pkg::*;
(
	input  wire logic        tdm_mode,
	input  wire logic        slot_ok,
	input  wire logic        right_half,
	input  wire logic [5:0]  slot_idx,
	input  wire logic [4:0]  bit_idx,
	input  wire logic [4:0]  slot_code,
	input  wire logic        src_on,
	input  wire logic        pin_sel,
	input  wire logic [31:0] sample,
	output logic             drive_a,
	output logic             drive_b,
	output logic             bit_out
);

	logic hit;

	always_comb begin
		// Codes 16..31 mean right half in the two-slot formats
		if (tdm_mode) begin
			hit = slot_ok && (slot_idx < ATX_TDM_SLOTS) && (slot_idx[4:0] == slot_code); // [RULE_04]
		end else begin
			hit = slot_ok && (slot_idx < ATX_HALF_SLOTS) && (right_half == slot_code[4])
				&& (slot_idx[3:0] == slot_code[3:0]); // [RULE_04]
		end
		drive_a = hit && src_on && !pin_sel; // [RULE_05] [RULE_12]
		drive_b = hit && src_on && pin_sel;  // [RULE_12]
		bit_out = sample[ATX_SAMPLE_MSB - bit_idx]; // [RULE_13]
	end

endmodule // atx_slot_lane

// File: tb/atx_host_model.sv
/*
 * Host audio processor model: makes the frame clock and captures each frame
 * from both serial data pins, reporting where and how long each was driven.
 * Assumes the bit clock comes from the bench and runs free.
 */
module atx_host_model
	import atx_pkg::*;
#(
	parameter int HALF = 300
)
(
	input  wire logic        bit_clk,
	input  wire logic        rst,
	input  wire logic        sd_a_o,
	input  wire logic        sd_a_oe,
	input  wire logic        sd_b_o,
	input  wire logic        sd_b_oe,
	output logic             frame_sync,
	output int               frm_cnt,
	output int               res_first [2],
	output int               res_cnt   [2],
	output logic      [31:0] res_word  [2]
);
	timeunit 1ns;
	timeprecision 100ps;

	int          pos;
	int          first [2];
	int          cnt   [2];
	logic [31:0] word  [2];
	wire  logic  [1:0] line;

	// Released pins float, so a stale level is never taken as data
	assign line[0] = sd_a_oe ? sd_a_o : 1'bz;
	assign line[1] = sd_b_oe ? sd_b_o : 1'bz;

	// --------------------------------------------------------------
	// Frame clock: high half then low half
	// --------------------------------------------------------------
	always @(posedge bit_clk or posedge rst) begin
		if (rst) begin
			pos <= 0;
			frame_sync <= 1'b0;
		end else begin
			pos <= (pos == 2 * HALF - 1) ? 0 : pos + 1;
			frame_sync <= (pos == 2 * HALF - 1) || (pos < HALF - 1);
		end
	end

	// --------------------------------------------------------------
	// Capture, MSB first, results latched at frame end
	// --------------------------------------------------------------
	always @(negedge bit_clk or posedge rst) begin
		if (rst) begin
			frm_cnt = 0;
		end
		for (int i = 0; i < 2; i++) begin
			if (pos == 0) begin
				first[i] = -1;
				cnt[i] = 0;
				word[i] = 32'h0;
			end
			if (line[i] !== 1'bz) begin
				if (first[i] < 0)
					first[i] = pos;
				cnt[i]++;
				word[i] = {word[i][30:0], line[i]};
			end
			if (pos == 2 * HALF - 1) begin
				res_first[i] = first[i];
				res_cnt[i] = cnt[i];
				res_word[i] = word[i];
			end
		end
		if (pos == 2 * HALF - 1 && !rst)
			frm_cnt++;
	end
endmodule // atx_host_model

// File: tb/audio_tx_slot_channel_config_bench.sv
/*
 * Self-checking bench for the channel 2 to 4 transmit slot configuration.
 * Assumes the host model frames the link and reports each captured frame.
 */
module audio_tx_slot_channel_config_bench
	import atx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          HALF = 300;
	localparam logic [31:0] D2   = 32'hA5C30F96;
	localparam logic [31:0] D3M  = 32'h3C5A96E1;
	localparam logic [31:0] D3V  = 32'hC0DE7A52;
	localparam logic [31:0] D4M  = 32'h6B19D4E3;
	localparam logic [31:0] D4T  = 32'h9E2758B1;

	typedef struct {
		logic [7:0] addr;
		logic [7:0] wd;
		logic [2:0] psel;
		logic [1:0] fmt;
		logic [1:0] wlc;
		int         wl;
		logic       pin;
		int         first;
		logic [31:0] data;
	} atx_case_type;

	logic        REF_CLK, RST, REG_WR, REG_RD, BIT_CLK, FRAME_SYNC;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
	logic [2:0]  CH_PIN_SEL;
	logic [1:0]  FORMAT, WORD_LEN;
	logic        SDOUT_A_O, SDOUT_A_OE, SDOUT_B_O, SDOUT_B_OE;
	int          fails, compares, frm_cnt;
	int          res_first [2];
	int          res_cnt   [2];
	logic [31:0] res_word  [2];

	atx_tx_slot_cfg dut_u (.REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CH_PIN_SEL(CH_PIN_SEL),
		.FORMAT(FORMAT), .WORD_LEN(WORD_LEN), .BIT_CLK(BIT_CLK), .FRAME_SYNC(FRAME_SYNC),
		.CH2_CONV_DATA(D2), .CH3_MIC_DATA(D3M), .CH3_VBAT_DATA(D3V), .CH4_MIC_DATA(D4M),
		.CH4_TEMP_DATA(D4T), .SDOUT_A_O(SDOUT_A_O), .SDOUT_A_OE(SDOUT_A_OE),
		.SDOUT_B_O(SDOUT_B_O), .SDOUT_B_OE(SDOUT_B_OE));

	atx_host_model #(.HALF(HALF)) host_u (.bit_clk(BIT_CLK), .rst(RST), .sd_a_o(SDOUT_A_O),
		.sd_a_oe(SDOUT_A_OE), .sd_b_o(SDOUT_B_O), .sd_b_oe(SDOUT_B_OE), .frame_sync(FRAME_SYNC),
		.frm_cnt(frm_cnt), .res_first(res_first), .res_cnt(res_cnt), .res_word(res_word));

	// --------------------------------------------------------------
	// Clocks; link clock offset so the two never line up
	// --------------------------------------------------------------
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	initial begin
		BIT_CLK = 1'b0;
		#7.3;
		forever #15 BIT_CLK = ~BIT_CLK;
	end

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask

	// Read data stands until the next read, so it is taken a cycle late
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge REF_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		@(posedge REF_CLK);
		@(negedge REF_CLK);
		d = REG_RDATA;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] d;
		reg_rd(a, d);
		chk_reg(d, exp, msg);
	endtask

	// Three frames: the first may straddle the config crossing
	task automatic chk_frame(input logic pin, input int first, input int wl, input logic [31:0] data,
		input string msg);
		int n0;
		bit on;
		n0 = frm_cnt;
		for (int i = 0; i < 10000 && frm_cnt < n0 + 3; i++)
			@(posedge REF_CLK);
		// A link that never frames counts against the run
		if (frm_cnt < n0 + 3) begin
			fails++;
			$display("CHECK FAILED at %0t: %s no frames", $time, msg);
		end
		for (int p = 0; p < 2; p++) begin
			on = (p == int'(pin)) && (first >= 0);
			chk_pin(32'(res_first[p]), on ? 32'(first) : 32'hFFFFFFFF, msg);
			chk_pin(32'(res_cnt[p]), on ? 32'(wl) : 32'h0, msg);
			chk_pin(res_word[p], on ? data >> (32 - wl) : 32'h0, msg);
		end
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		rd_chk(ATX_OFS_CH2, 8'h21, "ch2 reset");
		rd_chk(8'h20, 8'h02, "ch3 reset");
		rd_chk(8'h21, 8'h03, "ch4 reset");
		rd_chk(8'h22, 8'h00, "unmapped read");
		chk_frame(1'b0, 4 + 16 * 1, 16, D2, "default frame");
		$display("test reset done");
	endtask

	// Host software keeps reserved bits at zero; they must also read back zero
	task automatic t_reserved();
		reg_wr(ATX_OFS_CH2, 8'h25);
		rd_chk(ATX_OFS_CH2, 8'h25, "ch2 reserved");
		reg_wr(8'h20, 8'h24);
		rd_chk(8'h20, 8'h24, "ch3 reserved");
		reg_wr(8'h21, 8'h05);
		rd_chk(8'h21, 8'h05, "ch4 reserved");
		reg_wr(8'h22, 8'h5A);
		rd_chk(8'h22, 8'h00, "unmapped write");
		reg_wr(ATX_OFS_CH2, 8'h00);
		reg_wr(8'h20, 8'h00);
		reg_wr(8'h21, 8'h00);
		$display("test reserved done");
	endtask

	task automatic t_table();
		atx_case_type c [13] = '{
			'{8'h1F, 8'h00, 3'h0, 2'h0, 2'h0, 16, 1'b0, -1, 32'h0},
			'{8'h20, 8'h25, 3'h2, 2'h0, 2'h0, 16, 1'b1, 4 + 16 * 5, D3M},
			'{8'h20, 8'h45, 3'h0, 2'h0, 2'h0, 16, 1'b0, 4 + 16 * 5, D3V},
			'{8'h21, 8'h3F, 3'h4, 2'h0, 2'h0, 16, 1'b1, 4 + 16 * 31, D4M},
			'{8'h21, 8'h40, 3'h0, 2'h0, 2'h0, 16, 1'b0, 4, D4T},
			'{8'h21, 8'h03, 3'h0, 2'h0, 2'h0, 16, 1'b0, -1, 32'h0},
			'{8'h1F, 8'h22, 3'h0, 2'h0, 2'h3, 32, 1'b0, 4 + 32 * 2, D2},
			'{8'h1F, 8'h30, 3'h0, 2'h2, 2'h0, 16, 1'b0, HALF + 4, D2},
			'{8'h1F, 8'h30, 3'h1, 2'h1, 2'h0, 16, 1'b1, 5, D2},
			'{8'h1F, 8'h21, 3'h0, 2'h1, 2'h0, 16, 1'b0, HALF + 5 + 16, D2},
			'{8'h20, 8'h21, 3'h0, 2'h0, 2'h1, 20, 1'b0, 4 + 20 * 1, D3M},
			'{8'h21, 8'h42, 3'h4, 2'h0, 2'h2, 24, 1'b1, 4 + 24 * 2, D4T},
			'{8'h1F, 8'h21, 3'h0, 2'h3, 2'h0, 16, 1'b0, -1, 32'h0}
		};
		for (int i = 0; i < 13; i++) begin
			@(posedge REF_CLK);
			FORMAT <= c[i].fmt;
			WORD_LEN <= c[i].wlc;
			CH_PIN_SEL <= c[i].psel;
			reg_wr(c[i].addr, c[i].wd);
			chk_frame(c[i].pin, c[i].first, c[i].wl, c[i].data, $sformatf("case %0d", i));
			reg_wr(c[i].addr, 8'h00);
		end
		$display("test table done");
	endtask

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		fails = 0;
		compares = 0;
		RST = 1'b1;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		CH_PIN_SEL = 3'h0;
		FORMAT = 2'h0;
		WORD_LEN = 2'h0;
		repeat (6) @(posedge REF_CLK);
		RST <= 1'b0;
		t_reset();
		t_reserved();
		t_table();
		finish_test();
	end

	initial begin
		#900000;
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule // audio_tx_slot_channel_config_bench
